// *** dv/isc_checker.sv ***
// Purpose: Port-level assertions for the interrupt and sleep controller
// Assumes: Only the top-level ports are visible
// Notes:   Sleep entry is judged two cycles after its command
`timescale 1ns/100ps
module isc_checker
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // CPU side
  input wire logic [2:0]  CPU_CMD,
  input wire logic        CPU_BOUNDARY,
  input wire logic [15:0] CPU_PC,
  input wire logic        INT_TAKE,
  input wire logic [15:0] PC_LOAD,
  input wire logic        PC_LOAD_EN,
  input wire logic        AF_LOAD_EN,
  input wire logic        CPU_HALT,
  // Stack memory
  input wire logic [7:0]  MEM_ADDR,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic        MEM_WR,
  input wire logic        MEM_RD,
  // Power control
  input wire logic        SYSCLK_GATE,
  input wire logic [2:0]  OSC_RUN,
  input wire logic        PROG_MEM_OFF
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  a_take_vector: assert property (INT_TAKE |-> PC_LOAD_EN && PC_LOAD == VECTOR_ADDR)
    else $error("take did not vector");
  a_push_low: assert property (INT_TAKE |-> MEM_WR && MEM_WDATA == $past(CPU_PC[7:0]))
    else $error("low pc byte not pushed");
  a_push_high: assert property (INT_TAKE |=> MEM_WR && MEM_ADDR == $past(MEM_ADDR) + 8'h01
    && MEM_WDATA == $past(CPU_PC[15:8], 2))
    else $error("high pc byte not pushed");
  a_take_cause: assert property (INT_TAKE |-> $past(CPU_BOUNDARY) && !$past(CPU_HALT))
    else $error("take off boundary");
  a_take_once: assert property (INT_TAKE |=> !INT_TAKE [*4])
    else $error("take repeated");
  a_ret_pops: assert property (PC_LOAD_EN && !INT_TAKE |-> $past(MEM_RD, 2) && $past(MEM_RD, 3))
    else $error("pc reload without stack reads");
  a_restore_pops: assert property (AF_LOAD_EN |-> $past(MEM_RD, 2) && $past(MEM_RD, 3))
    else $error("restore without stack reads");
  a_sleep_pmem: assert property (SYSCLK_GATE |-> PROG_MEM_OFF && CPU_HALT)
    else $error("sleep without halt or memory off");
  a_light_osc: assert property ($rose(SYSCLK_GATE) && $past(CPU_CMD, 2) == CMD_LIGHT_SLEEP
    |-> OSC_RUN == $past(OSC_RUN) && OSC_RUN[OSC_SLOW_BIT])
    else $error("light sleep changed oscillators");
  a_deep_osc: assert property ($rose(SYSCLK_GATE) && $past(CPU_CMD, 2) == CMD_DEEP_SLEEP
    |-> OSC_RUN == 3'h0)
    else $error("deep sleep left oscillator on");
  a_wake_plain: assert property ($fell(CPU_HALT) |-> !PC_LOAD_EN)
    else $error("wake moved the pc");

  c_take: cover property (INT_TAKE);
  c_restore: cover property (AF_LOAD_EN);
  c_wake: cover property ($fell(SYSCLK_GATE));
endmodule : isc_checker

bind isc_top isc_checker isc_checker_i (.CLK_SYS, .RESET, .CPU_CMD, .CPU_BOUNDARY, .CPU_PC, .INT_TAKE,
  .PC_LOAD, .PC_LOAD_EN, .AF_LOAD_EN, .CPU_HALT, .MEM_ADDR, .MEM_WDATA, .MEM_WR, .MEM_RD,
  .SYSCLK_GATE, .OSC_RUN, .PROG_MEM_OFF);

// *** dv/isc_stack_mem.sv ***
// Purpose: Stack memory model at the far side of the memory port
// Assumes: Read data answered in the cycle after MEM_RD only
// Notes:   Outside that cycle the data lines invert each cycle so stale data passes only every other cycle
`timescale 1ns/100ps
module isc_stack_mem (
  // Clock
  input  wire logic       CLK_SYS,
  // Memory port
  input  wire logic [7:0] MEM_ADDR,
  input  wire logic [7:0] MEM_WDATA,
  input  wire logic       MEM_WR,
  input  wire logic       MEM_RD,
  output logic      [7:0] MEM_RDATA
);
  logic [7:0] mem [256];

  always @(posedge CLK_SYS) begin
    if (MEM_WR) mem[MEM_ADDR] <= MEM_WDATA;
    MEM_RDATA <= MEM_RD ? mem[MEM_ADDR] : ~MEM_RDATA;
  end
endmodule : isc_stack_mem

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the interrupt and sleep controller
// Assumes: CPU sits at an instruction boundary throughout
// Notes:   Fast wake only; the long normal wake is never run, and no assertion checks wake latency
`timescale 1ns/100ps
module testbench
  import isc_pkg::*;
;
  logic        CLK_SYS, RESET, REG_WR, REG_RD, SLOW_TICK, CPU_BOUNDARY, INT_TAKE, PC_LOAD_EN;
  logic        AF_LOAD_EN, CPU_HALT, MEM_WR, MEM_RD, SYSCLK_GATE, PROG_MEM_OFF;
  logic [3:0]  REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA, CPU_ACC, CPU_FLAGS, ACC_LOAD, FLAGS_LOAD, MEM_ADDR, MEM_WDATA;
  logic [7:0]  MEM_RDATA, src, rd;
  logic [15:0] PIN_IN, CPU_PC, PC_LOAD;
  logic [2:0]  CPU_CMD, OSC_RUN, TIMER_RUN;
  int          err_count, num_checks, k;
  integer      seed;

  isc_top isc_top_i (.CLK_SYS, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .EXT_PIN_REQ(src[1:0]), .ADC_REQ(src[2]), .TMR16_REQ(src[3]), .COMP_REQ(src[4]), .PWM0_REQ(src[5]),
    .TMR2_REQ(src[6]), .TMR3_REQ(src[7]), .PIN_IN, .SLOW_TICK, .CPU_CMD, .CPU_BOUNDARY, .CPU_PC,
    .CPU_ACC, .CPU_FLAGS, .INT_TAKE, .PC_LOAD, .PC_LOAD_EN, .ACC_LOAD, .FLAGS_LOAD, .AF_LOAD_EN,
    .CPU_HALT, .MEM_ADDR, .MEM_WDATA, .MEM_WR, .MEM_RD, .MEM_RDATA, .SYSCLK_GATE, .OSC_RUN,
    .PROG_MEM_OFF, .TIMER_RUN);
  isc_stack_mem isc_stack_mem_i (.CLK_SYS, .MEM_ADDR, .MEM_WDATA, .MEM_WR, .MEM_RD, .MEM_RDATA);

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic clk(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : clk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK_SYS);
    REG_WR    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD   <= 1'b0;
    #1 d = REG_RDATA;
  endtask : reg_rd

  task automatic cmd(input isc_cmd_t c);
    @(posedge CLK_SYS);
    CPU_CMD <= c;
    @(posedge CLK_SYS);
    CPU_CMD <= CMD_NONE;
  endtask : cmd

  // Waits for 0 take, 1 pc load, 2 acc load, 3 awake; bounded so a hang ends the run
  task automatic await(input int w);
    for (int n = 0; n < 40; n++) begin
      @(posedge CLK_SYS);
      #1;
      if ((w == 0 && INT_TAKE === 1'b1) || (w == 1 && PC_LOAD_EN === 1'b1) ||
          (w == 2 && AF_LOAD_EN === 1'b1) || (w == 3 && CPU_HALT === 1'b0)) return;
    end
    err_count++;
    $display("mismatch at %0t: wait %h timed out", $time, w);
    end_of_test();
  endtask : await

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge CLK_SYS);
      SLOW_TICK <= 1'b1;
      @(posedge CLK_SYS);
      SLOW_TICK <= 1'b0;
      clk(2);
    end
  endtask : ticks

  function automatic logic edge_hit(input logic [1:0] m, input logic rising);
    return (m == EDGE_BOTH) || (m == EDGE_RISE && rising) || (m == EDGE_FALL && !rising);
  endfunction : edge_hit

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0]  m;
    logic [15:0] pc;
    logic [11:0] rst_tab [9];
    rst_tab = '{{ADDR_ENABLE, RST_ENABLE}, {ADDR_FLAGS, 8'h00}, {ADDR_EDGE, RST_EDGE}, {ADDR_SP, RST_SP},
      {ADDR_MISC, RST_MISC}, {ADDR_DIGIN_LO, RST_DIGIN[7:0]}, {ADDR_DIGIN_HI, RST_DIGIN[15:8]},
      {ADDR_OSC, 5'h00, RST_OSC}, {4'hF, 8'h00}};
    seed = 32'hF6DBB020;
    {REG_ADDR, REG_WDATA, REG_WR, REG_RD, src, PIN_IN, SLOW_TICK, CPU_CMD, CPU_PC} = '0;
    {CPU_ACC, CPU_FLAGS, err_count, num_checks} = '0;
    CPU_BOUNDARY = 1'b1;
    RESET = 1'b1;
    clk(16);
    RESET <= 1'b0;
    chk({OSC_RUN, TIMER_RUN}, 6'h1F);
    foreach (rst_tab[i]) begin
      reg_rd(rst_tab[i][11:8], rd);
      chk(rd, rst_tab[i][7:0]);
    end
    $display("test reset done");
    // Every edge mode on a random line, with the line's enable left off
    for (int j = 0; j < 3; j++) begin
      m = (j == 0) ? EDGE_BOTH : (j == 1) ? EDGE_RISE : EDGE_FALL;
      k = $unsigned($random(seed)) % 8;
      reg_wr(ADDR_EDGE, {4{m}});
      reg_wr(ADDR_FLAGS, 8'h00);
      src[k] <= 1'b1;
      clk(6);
      reg_rd(ADDR_FLAGS, rd);
      chk(rd, 32'(edge_hit(m, 1'b1)) << k);
      reg_wr(ADDR_FLAGS, 8'h00);
      src[k] <= 1'b0;
      clk(6);
      reg_rd(ADDR_FLAGS, rd);
      chk(rd, 32'(edge_hit(m, 1'b0)) << k);
    end
    reg_wr(ADDR_EDGE, {4{EDGE_RISE}});
    reg_wr(ADDR_FLAGS, 8'h00);
    src <= 8'hFF;
    clk(6);
    reg_wr(ADDR_FLAGS, ~(8'h01 << k));
    reg_rd(ADDR_FLAGS, rd);
    chk(rd, 8'(~(8'h01 << k)));
    reg_wr(ADDR_FLAGS, 8'h00);
    reg_wr(ADDR_FLAGS, 8'hFF);
    reg_rd(ADDR_FLAGS, rd);
    chk(rd, 8'h00);
    src <= 8'h00;
    reg_wr(ADDR_EDGE, {4{EDGE_BOTH}});
    $display("test flags done");
    // Take, save, restore and return with random core state
    pc = 16'($random(seed));
    CPU_PC <= pc;
    CPU_ACC <= 8'($random(seed));
    CPU_FLAGS <= 8'($random(seed));
    reg_wr(ADDR_SP, 8'h20);
    reg_wr(ADDR_FLAGS, 8'h00);
    reg_wr(ADDR_ENABLE, 8'h01 << k);
    src[k] <= 1'b1;
    clk(6);
    cmd(CMD_GIE_ON);
    await(0);
    chk(PC_LOAD, VECTOR_ADDR);
    reg_rd(ADDR_FLAGS, rd);
    chk(rd, 8'h01 << k);
    reg_rd(ADDR_SP, rd);
    chk(rd, 8'h22);
    chk({isc_stack_mem_i.mem[8'h21], isc_stack_mem_i.mem[8'h20]}, pc);
    reg_rd(ADDR_STATUS, rd);
    chk(rd[0], 1'b0);
    cmd(CMD_SAVE);
    clk(4);
    reg_rd(ADDR_SP, rd);
    chk(rd, 8'h24);
    cmd(CMD_RESTORE);
    await(2);
    chk({ACC_LOAD, FLAGS_LOAD}, {CPU_ACC, CPU_FLAGS});
    reg_wr(ADDR_FLAGS, ~(8'h01 << k));
    cmd(CMD_RETURN);
    await(1);
    chk(PC_LOAD, pc);
    reg_rd(ADDR_SP, rd);
    chk(rd, 8'h20);
    reg_rd(ADDR_STATUS, rd);
    chk(rd[0], 1'b1);
    $display("test interrupt done");
    // A pending request must wait for the global enable
    cmd(CMD_GIE_OFF);
    src[k] <= 1'b0;
    repeat (20) begin
      @(posedge CLK_SYS);
      #1 chk(INT_TAKE, 1'b0);
    end
    cmd(CMD_GIE_ON);
    await(0);
    clk(3);
    reg_wr(ADDR_ENABLE, 8'h00);
    reg_wr(ADDR_FLAGS, 8'h00);
    $display("test global enable done");
    // Light sleep, fast wake from timer_two; timer sources slow, sysclk, stopped xtal
    reg_wr(ADDR_MISC, 8'h20);
    reg_wr(ADDR_TMRSRC, 8'h32);
    cmd(CMD_LIGHT_SLEEP);
    clk(3);
    chk({SYSCLK_GATE, PROG_MEM_OFF, CPU_HALT, OSC_RUN, TIMER_RUN}, 9'h1D9);
    src[6] <= 1'b1;
    ticks(40);
    // The clock gate opens once wake-up starts; the core stays halted for the count
    chk(CPU_HALT, 1'b1);
    ticks(8);
    await(3);
    chk(CPU_HALT, 1'b0);
    $display("test light sleep done");
    // Deep sleep ignores timers and pins without digital input
    reg_wr(ADDR_DIGIN_LO, 8'hF7);
    cmd(CMD_DEEP_SLEEP);
    clk(3);
    chk({OSC_RUN, PROG_MEM_OFF}, 4'h1);
    src[6] <= 1'b0;
    PIN_IN[3] <= 1'b1;
    ticks(50);
    chk(SYSCLK_GATE, 1'b1);
    PIN_IN[4] <= 1'b1;
    ticks(40);
    chk(CPU_HALT, 1'b1);
    chk(OSC_RUN, 3'h2);
    ticks(8);
    await(3);
    chk(OSC_RUN, 3'h3);
    reg_rd(ADDR_DIGIN_LO, rd);
    chk(rd, 8'hF7);
    $display("test deep sleep done");
    end_of_test();
  end
endmodule : testbench

// *** verilog/isc_edge.sv ***
`timescale 1ns/100ps
// Purpose: Edge detection for the eight request lines
// Assumes: Inputs already synchronised to CLK_SYS
// Notes:   One-cycle hit per selected edge
module isc_edge
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic   CLK_SYS,
  input wire logic   RESET,
  // Event bundle
  isc_evt_if.unit    evt
);
  logic [7:0] prev_q;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= evt.src;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (evt.mode[i])
        EDGE_RISE: evt.hit[i] = evt.src[i] & ~prev_q[i];
        EDGE_FALL: evt.hit[i] = ~evt.src[i] & prev_q[i];
        default:   evt.hit[i] = evt.src[i] ^ prev_q[i];
      endcase
    end
  end
endmodule : isc_edge

// *** verilog/isc_mem_if.sv ***
`timescale 1ns/100ps
// Purpose: Request event bundle between the top level and the edge unit
// Assumes: Single clock
// Notes:   Carries the synchronised request lines and the flag set pulses
interface isc_evt_if;
  logic [7:0] src;
  logic [1:0] mode [8];
  logic [7:0] hit;
  modport unit (input src, input mode, output hit);
  modport top  (output src, output mode, input hit);
endinterface : isc_evt_if

// *** verilog/isc_pkg.sv ***
// Purpose: Constants shared by the interrupt and sleep controller files
// Assumes: 100 MHz CLK_SYS; slow oscillator ticks arrive as a pulse input
// Notes:   Register map and most field positions live here; edge, timer source and status fields are laid out in the top level
// Function
// - Eight request lines, two shared pin groups, each with an enable bit.
// - Flags set only by hardware events, cleared only by flag register writes.
// - Each flag sets on rising, falling or both edges per edge select.
// - Service only while global enable set; on/off instructions change it.
// - Flags still set when their enable bit is zero.
// - Taking interrupt writes 16-bit PC at stack pointer, then pointer plus two.
// - Taking interrupt clears global enable and vectors to 0x010.
// - Return reloads PC from stack, pointer minus two, re-enables globally.
// - Save pushes accumulator and flags; restore pops them back.
// - Reading request flags shows which sources raised the interrupt.
// - Light sleep gates only system clock; oscillators keep their state.
// - Slow oscillator stays enabled in light sleep; wake restarts from it.
// - In light sleep timers halt if on system clock or disabled oscillator.
// - Light sleep wakes on enabled pin toggle or any of three timers.
// - Deep sleep stops all three oscillators, keeping SRAM and registers.
// - Deep sleep wakes only on toggle of a digital-input-enabled pin.
// - Program memory powered off in both sleep modes.
// - After wake, execution continues after the sleep instruction.
// - Wake latency 45 or 3000 slow clocks, chosen by misc bit 5.
package isc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_ENABLE   = 4'h0;
  localparam logic [3:0] ADDR_FLAGS    = 4'h1;
  localparam logic [3:0] ADDR_EDGE     = 4'h2;
  localparam logic [3:0] ADDR_SP       = 4'h3;
  localparam logic [3:0] ADDR_MISC     = 4'h4;
  localparam logic [3:0] ADDR_DIGIN_LO = 4'h5;
  localparam logic [3:0] ADDR_DIGIN_HI = 4'h6;
  localparam logic [3:0] ADDR_OSC      = 4'h7;
  localparam logic [3:0] ADDR_TMRSRC   = 4'h8;
  localparam logic [3:0] ADDR_STATUS   = 4'h9;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int           MISC_FAST_WAKE_BIT = 5;
  localparam int           OSC_FAST_BIT       = 0;
  localparam int           OSC_SLOW_BIT       = 1;
  localparam int           OSC_XTAL_BIT       = 2;
  localparam logic [7:0]   RST_ENABLE         = 8'h00;
  localparam logic [7:0]   RST_EDGE           = 8'h00;
  localparam logic [7:0]   RST_SP             = 8'h00;
  localparam logic [7:0]   RST_MISC           = 8'h00;
  localparam logic [15:0]  RST_DIGIN          = 16'hFFFF;
  localparam logic [2:0]   RST_OSC            = 3'h3;
  localparam logic [15:0]  VECTOR_ADDR        = 16'h0010;
  localparam logic [7:0]   STACK_STEP         = 8'h02;
  // Wake latency in slow-oscillator clocks
  localparam logic [11:0]  WAKE_FAST_TICKS    = 12'd45;
  localparam logic [11:0]  WAKE_NORMAL_TICKS  = 12'd3000;
  // Edge select codes per pair of lines, two bits each in the 8-bit edge register
  localparam logic [1:0]   EDGE_BOTH          = 2'h0;
  localparam logic [1:0]   EDGE_RISE          = 2'h1;
  localparam logic [1:0]   EDGE_FALL          = 2'h2;
  // ----------------------------------------------------------------
  // CPU requests
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE, CMD_GIE_ON, CMD_GIE_OFF, CMD_RETURN,
    CMD_SAVE, CMD_RESTORE, CMD_LIGHT_SLEEP, CMD_DEEP_SLEEP
  } isc_cmd_t;
endpackage : isc_pkg

// *** verilog/isc_top.sv ***
`timescale 1ns/100ps
// Purpose: Interrupt gathering, stack sequencing and sleep control
// Assumes: CPU issues one command per cycle at instruction boundaries
// Notes:   Stack memory reached byte-wide over a simple write/read port
module isc_top
  import isc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // Request sources
  input  wire logic [1:0]  EXT_PIN_REQ,
  input  wire logic        ADC_REQ,
  input  wire logic        TMR16_REQ,
  input  wire logic        COMP_REQ,
  input  wire logic        PWM0_REQ,
  input  wire logic        TMR2_REQ,
  input  wire logic        TMR3_REQ,
  input  wire logic [15:0] PIN_IN,
  input  wire logic        SLOW_TICK,
  // CPU side
  input  wire logic [2:0]  CPU_CMD,
  input  wire logic        CPU_BOUNDARY,
  input  wire logic [15:0] CPU_PC,
  input  wire logic [7:0]  CPU_ACC,
  input  wire logic [7:0]  CPU_FLAGS,
  output logic             INT_TAKE,
  output logic [15:0]      PC_LOAD,
  output logic             PC_LOAD_EN,
  output logic [7:0]       ACC_LOAD,
  output logic [7:0]       FLAGS_LOAD,
  output logic             AF_LOAD_EN,
  output logic             CPU_HALT,
  // Stack memory
  output logic [7:0]       MEM_ADDR,
  output logic [7:0]       MEM_WDATA,
  output logic             MEM_WR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  // Power control
  output logic             SYSCLK_GATE,
  output logic [2:0]       OSC_RUN,
  output logic             PROG_MEM_OFF,
  output logic [2:0]       TIMER_RUN
);
  // ----------------------------------------------------------------
  // Synchronisers for pins and outside sources
  // ----------------------------------------------------------------
  logic [7:0]  req_m_q, req_s_q;
  logic [15:0] pin_m_q, pin_s_q, pin_p_q;
  logic        tick_m_q, tick_s_q;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      req_m_q  <= 8'h00;
      req_s_q  <= 8'h00;
      pin_m_q  <= 16'h0000;
      pin_s_q  <= 16'h0000;
      pin_p_q  <= 16'h0000;
      tick_m_q <= 1'b0;
      tick_s_q <= 1'b0;
    end else begin
      req_m_q  <= {TMR3_REQ, TMR2_REQ, PWM0_REQ, COMP_REQ, TMR16_REQ, ADC_REQ, EXT_PIN_REQ};
      req_s_q  <= req_m_q;
      pin_m_q  <= PIN_IN;
      pin_s_q  <= pin_m_q;
      pin_p_q  <= pin_s_q;
      tick_m_q <= SLOW_TICK;
      tick_s_q <= tick_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0]  enable_q, edge_q, sp_q, misc_q, tmrsrc_q;
  logic [15:0] digin_q;
  logic [2:0]  osc_q;
  logic [7:0]  flags_q;
  logic        gie_q;
  logic        sp_up, sp_dn;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      enable_q <= RST_ENABLE;
      edge_q   <= RST_EDGE;
      misc_q   <= RST_MISC;
      digin_q  <= RST_DIGIN;
      osc_q    <= RST_OSC;
      tmrsrc_q <= 8'h00;
    end else if (REG_WR) begin
      case (REG_ADDR)
        ADDR_ENABLE:   enable_q <= REG_WDATA;
        ADDR_EDGE:     edge_q   <= REG_WDATA;
        ADDR_MISC:     misc_q   <= REG_WDATA;
        ADDR_DIGIN_LO: digin_q[7:0]  <= REG_WDATA;
        ADDR_DIGIN_HI: digin_q[15:8] <= REG_WDATA;
        ADDR_OSC:      osc_q    <= REG_WDATA[2:0] | (3'h1 << OSC_SLOW_BIT);
        ADDR_TMRSRC:   tmrsrc_q <= REG_WDATA;
        default:       ;
      endcase
    end
  end

  // Edge select: two bits per group of lines, four groups of two lines
  isc_evt_if evt ();
  assign evt.src = req_s_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      evt.mode[i] = edge_q[2*(i/2) +: 2];
    end
  end

  isc_edge u_edge (
    .CLK_SYS (CLK_SYS),
    .RESET   (RESET),
    .evt     (evt)
  );

  // ----------------------------------------------------------------
  // Request flags: set wins over a software clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      flags_q <= 8'h00;
    end else if (REG_WR && REG_ADDR == ADDR_FLAGS) begin
      flags_q <= (flags_q & REG_WDATA) | evt.hit;
    end else begin
      flags_q <= flags_q | evt.hit;
    end
  end

  // ----------------------------------------------------------------
  // Stack sequencer
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_POP_HI, ST_POP_LO, ST_POP_DONE,
                ST_AF_HI, ST_AF_LO, ST_RA_HI, ST_RA_LO, ST_RA_DONE} isc_seq_t;
  isc_seq_t   seq_q;
  logic [7:0] hold_q;
  logic       pending;
  isc_cmd_t   cmd;
  logic       asleep_q;

  assign cmd     = isc_cmd_t'(CPU_CMD);
  assign pending = gie_q && |(flags_q & enable_q);
  assign sp_up   = (seq_q == ST_PUSH_HI) || (seq_q == ST_AF_LO);
  assign sp_dn   = (seq_q == ST_POP_LO) || (seq_q == ST_RA_LO);

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      seq_q      <= ST_IDLE;
      gie_q      <= 1'b0;
      hold_q     <= 8'h00;
      INT_TAKE   <= 1'b0;
      PC_LOAD    <= 16'h0000;
      PC_LOAD_EN <= 1'b0;
      ACC_LOAD   <= 8'h00;
      FLAGS_LOAD <= 8'h00;
      AF_LOAD_EN <= 1'b0;
      MEM_ADDR   <= 8'h00;
      MEM_WDATA  <= 8'h00;
      MEM_WR     <= 1'b0;
      MEM_RD     <= 1'b0;
    end else begin
      INT_TAKE   <= 1'b0;
      PC_LOAD_EN <= 1'b0;
      AF_LOAD_EN <= 1'b0;
      MEM_WR     <= 1'b0;
      MEM_RD     <= 1'b0;
      case (seq_q)
        ST_IDLE: begin
          if (CPU_BOUNDARY && !asleep_q && pending) begin
            INT_TAKE   <= 1'b1;
            gie_q      <= 1'b0;
            hold_q     <= CPU_PC[15:8];
            MEM_ADDR   <= sp_q;
            MEM_WDATA  <= CPU_PC[7:0];
            MEM_WR     <= 1'b1;
            PC_LOAD    <= VECTOR_ADDR;
            PC_LOAD_EN <= 1'b1;
            seq_q      <= ST_PUSH_LO;
          end else begin
            case (cmd)
              CMD_GIE_ON:  gie_q <= 1'b1;
              CMD_GIE_OFF: gie_q <= 1'b0;
              CMD_RETURN: begin
                MEM_ADDR <= sp_q - 8'h01;
                MEM_RD   <= 1'b1;
                seq_q    <= ST_POP_HI;
              end
              CMD_SAVE: begin
                hold_q    <= CPU_FLAGS;
                MEM_ADDR  <= sp_q;
                MEM_WDATA <= CPU_ACC;
                MEM_WR    <= 1'b1;
                seq_q     <= ST_AF_HI;
              end
              CMD_RESTORE: begin
                MEM_ADDR <= sp_q - 8'h01;
                MEM_RD   <= 1'b1;
                seq_q    <= ST_RA_HI;
              end
              default: ;
            endcase
          end
        end
        ST_PUSH_LO, ST_AF_HI: begin
          MEM_ADDR  <= MEM_ADDR + 8'h01;
          MEM_WDATA <= hold_q;
          MEM_WR    <= 1'b1;
          seq_q     <= (seq_q == ST_PUSH_LO) ? ST_PUSH_HI : ST_AF_LO;
        end
        ST_PUSH_HI, ST_AF_LO: seq_q <= ST_IDLE;
        ST_POP_HI, ST_RA_HI: begin
          MEM_ADDR <= MEM_ADDR - 8'h01;
          MEM_RD   <= 1'b1;
          seq_q    <= (seq_q == ST_POP_HI) ? ST_POP_LO : ST_RA_LO;
        end
        ST_POP_LO, ST_RA_LO: begin
          hold_q <= MEM_RDATA;
          seq_q  <= (seq_q == ST_POP_LO) ? ST_POP_DONE : ST_RA_DONE;
        end
        ST_POP_DONE: begin
          PC_LOAD    <= {hold_q, MEM_RDATA};
          PC_LOAD_EN <= 1'b1;
          gie_q      <= 1'b1;
          seq_q      <= ST_IDLE;
        end
        ST_RA_DONE: begin
          ACC_LOAD   <= MEM_RDATA;
          FLAGS_LOAD <= hold_q;
          AF_LOAD_EN <= 1'b1;
          seq_q      <= ST_IDLE;
        end
        default: seq_q <= ST_IDLE;
      endcase
    end
  end

  // Stack pointer: software writes, sequencer steps by two
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sp_q <= RST_SP;
    end else if (sp_up) begin
      sp_q <= sp_q + STACK_STEP;
    end else if (sp_dn) begin
      sp_q <= sp_q - STACK_STEP;
    end else if (REG_WR && REG_ADDR == ADDR_SP) begin
      sp_q <= REG_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  typedef enum {PW_ON, PW_LIGHT, PW_DEEP, PW_WAKE} isc_pwr_t;
  isc_pwr_t    pwr_q;
  logic        deep_q;
  logic [11:0] wake_cnt_q;
  logic        pin_wake, tmr_wake;

  assign asleep_q = (pwr_q != PW_ON);
  assign pin_wake = |((pin_s_q ^ pin_p_q) & digin_q);
  assign tmr_wake = |(evt.hit[7:6]) | evt.hit[3];

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      pwr_q      <= PW_ON;
      deep_q     <= 1'b0;
      wake_cnt_q <= 12'd0;
    end else begin
      case (pwr_q)
        PW_ON: begin
          if (seq_q == ST_IDLE && cmd == CMD_LIGHT_SLEEP) begin
            pwr_q  <= PW_LIGHT;
            deep_q <= 1'b0;
          end else if (seq_q == ST_IDLE && cmd == CMD_DEEP_SLEEP) begin
            pwr_q  <= PW_DEEP;
            deep_q <= 1'b1;
          end
        end
        PW_LIGHT: if (pin_wake || tmr_wake) pwr_q <= PW_WAKE;
        PW_DEEP:  if (pin_wake) pwr_q <= PW_WAKE;
        PW_WAKE: begin
          // Counted on slow ticks; restart resumes at the next instruction
          if (tick_s_q) begin
            if (wake_cnt_q == (misc_q[MISC_FAST_WAKE_BIT] ? WAKE_FAST_TICKS : WAKE_NORMAL_TICKS)
                              - 12'd1) begin
              wake_cnt_q <= 12'd0;
              pwr_q      <= PW_ON;
            end else begin
              wake_cnt_q <= wake_cnt_q + 12'd1;
            end
          end
        end
        default: pwr_q <= PW_ON;
      endcase
    end
  end

  // Power outputs and register read data, all registered
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      SYSCLK_GATE  <= 1'b0;
      CPU_HALT     <= 1'b0;
      OSC_RUN      <= RST_OSC;
      PROG_MEM_OFF <= 1'b0;
      TIMER_RUN    <= 3'h7;
      REG_RDATA    <= 8'h00;
    end else begin
      SYSCLK_GATE  <= (pwr_q == PW_LIGHT) || (pwr_q == PW_DEEP);
      CPU_HALT     <= asleep_q;
      PROG_MEM_OFF <= (pwr_q == PW_LIGHT) || (pwr_q == PW_DEEP);
      if (pwr_q == PW_DEEP) begin
        OSC_RUN <= 3'h0;
      end else if (pwr_q == PW_WAKE && deep_q) begin
        OSC_RUN <= 3'h1 << OSC_SLOW_BIT;
      end else begin
        OSC_RUN <= osc_q;
      end
      for (int t = 0; t < 3; t++) begin
        // Source code per timer: 0 system clock, 1..3 a named oscillator
        if (pwr_q == PW_LIGHT) begin
          TIMER_RUN[t] <= (tmrsrc_q[2*t +: 2] != 2'h0) && osc_q[tmrsrc_q[2*t +: 2] - 2'h1];
        end else begin
          TIMER_RUN[t] <= (pwr_q == PW_ON);
        end
      end
      REG_RDATA <= 8'h00;
      if (REG_RD) begin
        case (REG_ADDR)
          ADDR_ENABLE:   REG_RDATA <= enable_q;
          ADDR_FLAGS:    REG_RDATA <= flags_q;
          ADDR_EDGE:     REG_RDATA <= edge_q;
          ADDR_SP:       REG_RDATA <= sp_q;
          ADDR_MISC:     REG_RDATA <= misc_q;
          ADDR_DIGIN_LO: REG_RDATA <= digin_q[7:0];
          ADDR_DIGIN_HI: REG_RDATA <= digin_q[15:8];
          ADDR_OSC:      REG_RDATA <= {5'h00, osc_q};
          ADDR_TMRSRC:   REG_RDATA <= tmrsrc_q;
          ADDR_STATUS:   REG_RDATA <= {5'h00, deep_q, asleep_q, gie_q};
          default:       REG_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule : isc_top
